//--- verilog/ifa_pkg.sv
package ifa_pkg;
   // ***************************************************
   // Register map of the CPU register port
   // ***************************************************
   localparam logic [7:0] ADR_ADDR_HI = 8'hA0;
   localparam logic [7:0] ADR_ADDR_LO = 8'hA1;
   localparam logic [7:0] ADR_RDATA = 8'hA2;
   localparam logic [7:0] ADR_WDATA = 8'hA3;
   localparam logic [7:0] ADR_PTIM = 8'hA4;
   localparam logic [7:0] ADR_KEY = 8'hA5;
   localparam logic [7:0] ADR_CMD = 8'hA6;
   localparam logic [7:0] ADR_STATUS = 8'hA7;

   // Status bit positions
   localparam int ST_BUSY = 0;
   localparam int ST_REFUSED = 1;
   localparam int ST_KEY = 2;
   localparam int ST_FORCED = 3;
   localparam int ST_ISP_EN = 4;
   localparam int ST_SECURE = 5;

   // Command codes
   localparam logic [2:0] CMD_NONE = 3'h0;
   localparam logic [2:0] CMD_READ = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_PAGE = 3'h3;
   localparam logic [2:0] CMD_MASS = 3'h4;

   // ***************************************************
   // Values and timing
   // ***************************************************
   localparam logic [7:0] ADDR_RESET = 8'h00;
   localparam logic [7:0] PT_RESET = 8'h5A;
   localparam logic [5:0] KEY_VALUE = 6'h26;
   localparam logic [23:0] ENTRY_CODE = 24'h5E38AC;
   localparam logic [15:0] OPT_ALIAS_ADDR = 16'hFFFF;
   localparam logic [15:0] OPT_PHYS_ADDR = 16'h0FFF;
   localparam int CLK_NS = 50;
   localparam int INSTR_DIV = 10;
   localparam logic [3:0] DIV_LAST = 4'(INSTR_DIV - 1);
   localparam logic [3:0] KEY_CYCLES = 4'h8;
   localparam int DEBOUNCE_NS = 10000;
   localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_READ = 2'b01,
      S_PULSE = 2'b10
   } ifa_state_t;

   // True for the fourteen listed pulse timing codes
   function automatic logic ifa_code_ok(input logic [7:0] c);
      case (c)
         8'h00, 8'h01, 8'h02, 8'h04, 8'h07, 8'h0A, 8'h10,
         8'h18, 8'h28, 8'h45, 8'h49, 8'h4E, 8'h5A, 8'h6C:
            ifa_code_ok = 1'b1;
         default: ifa_code_ok = 1'b0;
      endcase
   endfunction
endpackage

//--- verilog/ifa_flash_access.sv
`timescale 1ns/10ps
// How it works
// - Both address byte registers clear to zero on reset.
// - Flash address 15..8 comes from the high address byte register.
// - Flash address 7..0 comes from the low address byte register.
// - All-ones address reaches the option register at the top location.
// - A flash read lands its byte in the read data register.
// - A write programs the write data byte at the addressed location.
// - Write and erase pulse width follows the pulse timing register.
// - Reset loads pulse timing with the code for a 10 MHz oscillator.
// - Program fetch from flash is blocked while flash is programmed.
// - Jump-to-boot enters boot ROM only while the key flag is set.
// - A matching key write sets the flag for 8 instruction cycles.
// - Key matches when written bits 7..2 equal 100110; bits 1..0 ignored.
// - In emulation a breakpoint freezes the key cycle counter.
// - The key flag keeps counting down during interrupt service.
// - Under reset a 24-bit code shifted in forces boot ROM start.
// - The entry code is 5E38AC, shifted least significant bit first.
// - A later plain reset with boot-select set starts from flash.
// - Forced entry leaves boot-select and security bits unchanged.
// - Only a mass erase clears a set security bit.
// - After forced entry the start pin is debounced low before ISP.
module ifa_flash_access #(
   parameter int PULSE_UNIT_CYC = 16,
   parameter int DEBOUNCE_CYC = ifa_pkg::DEBOUNCE_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // CPU register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Flash array
   output logic [15:0] flash_addr,
   output logic [7:0] flash_wdata,
   output logic flash_rd,
   input wire logic [7:0] flash_rdata,
   input wire logic flash_rvalid,
   output logic flash_prog,
   output logic flash_erase_page,
   output logic flash_erase_mass,
   output logic flash_fetch_block,
   // Core control
   input wire logic jump_to_boot,
   output logic jump_take_boot,
   output logic jump_take_flash,
   input wire logic emu_mode,
   input wire logic emu_break,
   output logic key_flag,
   // Option bits and boot selection
   input wire logic opt_boot_select,
   input wire logic opt_security,
   output logic boot_from_rom,
   output logic isp_enable,
   // Forced entry pins
   input wire logic entry_data_pin,
   input wire logic entry_clock_pin,
   input wire logic start_pin
);
   import ifa_pkg::*;

   localparam int KEY_CLKS = int'(KEY_CYCLES) * INSTR_DIV;

   // ***************************************************
   // Register file, operation sequencer and key flag
   // ***************************************************
   logic [7:0] adr_hi_ff, nxt_adr_hi, adr_lo_ff, nxt_adr_lo;
   logic [7:0] rd_ff, nxt_rd, wr_ff, nxt_wr, pt_ff, nxt_pt;
   logic [7:0] rdata_ff, nxt_rdata, status_w;
   logic [2:0] op_ff, nxt_op;
   logic [15:0] pcnt_ff, nxt_pcnt;
   logic refused_ff, nxt_refused;
   logic [3:0] div_ff, nxt_div, kcnt_ff, nxt_kcnt;
   logic freeze;
   ifa_state_t st_ff, nxt_st;
   logic forced_ff, isp_ff, boot_ff;

   function automatic logic hit(input logic [7:0] a);
      hit = reg_wr && (reg_addr == a);
   endfunction

   function automatic logic [15:0] pulse_len(input logic [7:0] c);
      pulse_len = 16'((32'(c) + 32'd1) * PULSE_UNIT_CYC);
   endfunction

   assign freeze = emu_mode && emu_break;

   always_comb begin
      nxt_adr_hi = adr_hi_ff;
      nxt_adr_lo = adr_lo_ff;
      nxt_rd = rd_ff;
      nxt_wr = wr_ff;
      nxt_pt = pt_ff;
      nxt_op = op_ff;
      nxt_pcnt = pcnt_ff;
      nxt_refused = refused_ff;
      nxt_st = st_ff;
      nxt_kcnt = kcnt_ff;
      nxt_div = (div_ff == DIV_LAST) ? 4'h0 : div_ff + 4'h1;
      status_w = 8'h00;
      status_w[ST_BUSY] = (st_ff != S_IDLE);
      status_w[ST_REFUSED] = refused_ff;
      status_w[ST_KEY] = (kcnt_ff != 4'h0);
      status_w[ST_FORCED] = forced_ff;
      status_w[ST_ISP_EN] = isp_ff;
      status_w[ST_SECURE] = opt_security;
      nxt_rdata = rdata_ff;
      if (reg_rd) begin
         case (reg_addr)
            ADR_ADDR_HI: nxt_rdata = adr_hi_ff;
            ADR_ADDR_LO: nxt_rdata = adr_lo_ff;
            ADR_RDATA: nxt_rdata = rd_ff;
            ADR_WDATA: nxt_rdata = wr_ff;
            ADR_PTIM: nxt_rdata = pt_ff;
            ADR_STATUS: nxt_rdata = status_w;
            default: nxt_rdata = 8'h00;
         endcase
      end
      if (hit(ADR_ADDR_HI)) begin
         nxt_adr_hi = reg_wdata;
      end
      if (hit(ADR_ADDR_LO)) begin
         nxt_adr_lo = reg_wdata;
      end
      if (hit(ADR_WDATA)) begin
         nxt_wr = reg_wdata;
      end
      // Timing is held steady while a pulse runs; bit 7 reads zero
      if (hit(ADR_PTIM) && st_ff == S_IDLE) begin
         nxt_pt = {1'b0, reg_wdata[6:0]};
      end
      if (hit(ADR_STATUS) && reg_wdata[ST_REFUSED]) begin
         nxt_refused = 1'b0;
      end
      case (st_ff)
         S_IDLE: begin
            if (hit(ADR_CMD)) begin
               case (reg_wdata[2:0])
                  CMD_READ: nxt_st = S_READ;
                  CMD_WRITE, CMD_PAGE, CMD_MASS: begin
                     if (ifa_code_ok(pt_ff)) begin
                        nxt_st = S_PULSE;
                        nxt_op = reg_wdata[2:0];
                        nxt_pcnt = pulse_len(pt_ff);
                     end else begin
                        nxt_refused = 1'b1;
                     end
                  end
                  default: nxt_st = S_IDLE;
               endcase
            end
         end
         S_READ: begin
            if (flash_rvalid) begin
               nxt_rd = flash_rdata;
               nxt_st = S_IDLE;
            end
         end
         S_PULSE: begin
            nxt_pcnt = pcnt_ff - 16'h1;
            if (pcnt_ff == 16'h1) begin
               nxt_st = S_IDLE;
               nxt_op = CMD_NONE;
            end
         end
         default: nxt_st = S_IDLE;
      endcase
      // Counts on in any state of the core, interrupt or not, except a breakpoint in emulation mode
      if (kcnt_ff != 4'h0 && div_ff == DIV_LAST && !freeze) begin
         nxt_kcnt = kcnt_ff - 4'h1;
      end
      if (hit(ADR_KEY)) begin
         if (reg_wdata[7:2] == KEY_VALUE) begin
            nxt_kcnt = KEY_CYCLES;
            nxt_div = 4'h0;
         end else begin
            nxt_kcnt = 4'h0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         adr_hi_ff <= ADDR_RESET;
         adr_lo_ff <= ADDR_RESET;
         rd_ff <= 8'h00;
         wr_ff <= 8'h00;
         pt_ff <= PT_RESET;
         rdata_ff <= 8'h00;
         op_ff <= CMD_NONE;
         pcnt_ff <= 16'h0;
         refused_ff <= 1'b0;
         st_ff <= S_IDLE;
         kcnt_ff <= 4'h0;
         div_ff <= 4'h0;
      end else begin
         adr_hi_ff <= nxt_adr_hi;
         adr_lo_ff <= nxt_adr_lo;
         rd_ff <= nxt_rd;
         wr_ff <= nxt_wr;
         pt_ff <= nxt_pt;
         rdata_ff <= nxt_rdata;
         op_ff <= nxt_op;
         pcnt_ff <= nxt_pcnt;
         refused_ff <= nxt_refused;
         st_ff <= nxt_st;
         kcnt_ff <= nxt_kcnt;
         div_ff <= nxt_div;
      end
   end

   // Option register is reached through the all-ones alias
   assign flash_addr = ({adr_hi_ff, adr_lo_ff} == OPT_ALIAS_ADDR) ?
      OPT_PHYS_ADDR : {adr_hi_ff, adr_lo_ff};
   assign flash_wdata = wr_ff;
   assign flash_rd = (st_ff == S_READ);
   assign flash_prog = (st_ff == S_PULSE) && (op_ff == CMD_WRITE);
   assign flash_erase_page = (st_ff == S_PULSE) && (op_ff == CMD_PAGE);
   // The array clears security only on a whole-array erase
   assign flash_erase_mass = (st_ff == S_PULSE) && (op_ff == CMD_MASS);
   assign flash_fetch_block = (st_ff != S_IDLE);
   assign key_flag = (kcnt_ff != 4'h0);
   assign jump_take_boot = jump_to_boot && key_flag;
   assign jump_take_flash = jump_to_boot && !key_flag;
   assign reg_rdata = rdata_ff;

   // ***************************************************
   // Forced boot entry and start pin debounce
   // ***************************************************
   logic [23:0] shift_ff, nxt_shift;
   logic eclk_ff;
   logic nxt_forced, nxt_isp, nxt_boot;
   logic [15:0] db_ff, nxt_db;

   always_comb begin
      nxt_shift = shift_ff;
      nxt_forced = forced_ff;
      nxt_isp = isp_ff;
      nxt_boot = boot_ff;
      nxt_db = db_ff;
      if (!rst_n) begin
         // Shifting only runs while reset is held
         if (entry_clock_pin && !eclk_ff) begin
            nxt_shift = {entry_data_pin, shift_ff[23:1]};
         end
         if (shift_ff == ENTRY_CODE) begin
            nxt_forced = 1'b1;
         end else begin
            nxt_forced = 1'b0;
         end
         // Option bits are only read here, never changed
         nxt_boot = nxt_forced || !opt_boot_select;
         nxt_isp = 1'b0;
         nxt_db = 16'h0;
      end else begin
         nxt_shift = 24'h0;
         if (forced_ff && !isp_ff) begin
            if (!start_pin) begin
               nxt_db = db_ff + 16'h1;
               if (db_ff == 16'(DEBOUNCE_CYC - 1)) begin
                  nxt_isp = 1'b1;
               end
            end else begin
               nxt_db = 16'h0;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      shift_ff <= nxt_shift;
      eclk_ff <= entry_clock_pin;
      forced_ff <= nxt_forced;
      isp_ff <= nxt_isp;
      boot_ff <= nxt_boot;
      db_ff <= nxt_db;
   end

   assign isp_enable = isp_ff;
   assign boot_from_rom = boot_ff;

   // ***************************************************
   // Assertions
   // ***************************************************
   logic [7:0] key_age;
   logic key_odd;
   logic [15:0] p_age;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         key_age <= 8'h00;
         key_odd <= 1'b0;
         p_age <= 16'h0;
      end else begin
         p_age <= (st_ff == S_PULSE) ? p_age + 16'h1 : 16'h0;
         if (hit(ADR_KEY)) begin
            key_age <= 8'h00;
            key_odd <= (reg_wdata[7:2] != KEY_VALUE);
         end else if (key_flag) begin
            key_age <= key_age + 8'h01;
            key_odd <= key_odd || freeze;
         end else begin
            key_age <= 8'h00;
            key_odd <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   AST_RESET_VALUES: assert property ($rose(rst_n) |->
      adr_hi_ff == ADDR_RESET && adr_lo_ff == ADDR_RESET && pt_ff == PT_RESET)
      else $error("address or timing register wrong after reset");
   AST_ADDR_ROUTE: assert property (hit(ADR_ADDR_HI) &&
      reg_wdata != 8'hFF |=> flash_addr[15:8] == $past(reg_wdata))
      else $error("high address byte not routed to flash");
   AST_OPT_ALIAS: assert property (
      adr_hi_ff == 8'hFF && adr_lo_ff == 8'hFF |-> flash_addr == 16'h0FFF)
      else $error("option alias not mapped");
   AST_READ_LAND: assert property (flash_rd && flash_rvalid
      |=> rd_ff == $past(flash_rdata) && !flash_rd)
      else $error("read data not captured");
   AST_PULSE_LEN: assert property (st_ff == S_IDLE &&
      $past(st_ff) == S_PULSE |-> p_age == pulse_len(pt_ff))
      else $error("pulse width does not follow timing code");
   AST_REFUSE: assert property (st_ff == S_IDLE && hit(ADR_CMD)
      && reg_wdata[2:0] == CMD_WRITE && !ifa_code_ok(pt_ff)
      |=> st_ff == S_IDLE && refused_ff)
      else $error("write with invalid timing code not refused");
   AST_FETCH_BLOCK: assert property (
      flash_prog || flash_erase_page || flash_erase_mass
      |-> flash_fetch_block)
      else $error("fetch not blocked during programming");
   AST_JUMP: assert property (jump_to_boot |->
      (jump_take_boot == key_flag) && (jump_take_flash == !key_flag))
      else $error("jump target does not follow key flag");
   AST_KEY_LEN: assert property ($fell(key_flag) && !key_odd
      |-> key_age == KEY_CLKS)
      else $error("key flag length is not 8 instruction cycles");
   AST_KEY_BAD: assert property (hit(ADR_KEY) &&
      reg_wdata[7:2] != KEY_VALUE |=> !key_flag)
      else $error("mismatching key set the flag");
   AST_KEY_FREEZE: assert property (freeze && key_flag &&
      !hit(ADR_KEY) |=> kcnt_ff == $past(kcnt_ff))
      else $error("key counter moved during breakpoint");
   AST_DEBOUNCE: assert property ($rose(isp_ff) |->
      forced_ff && $past(db_ff) == 16'(DEBOUNCE_CYC - 1))
      else $error("isp enabled without full debounce");

   COV_KEY_JUMP: cover property (key_flag && jump_to_boot);
   COV_MASS: cover property ($rose(flash_erase_mass));
   COV_REFUSED: cover property ($rose(refused_ff));
   COV_ISP: cover property ($rose(isp_ff));
endmodule

//--- verif/ifa_host_model.sv
`timescale 1ns/10ps
module ifa_host_model (
   // Clock
   input wire logic clock,
   // Pins toward the device
   output logic rst_n,
   output logic entry_data_pin,
   output logic entry_clock_pin,
   output logic start_pin
);
   initial begin
      rst_n = 1'b0;
      entry_data_pin = 1'b0;
      entry_clock_pin = 1'b0;
      start_pin = 1'b1;
   end

   task automatic hold_reset(input int n);
      rst_n <= 1'b0;
      start_pin <= 1'b1;
      repeat (n) @(posedge clock);
      rst_n <= 1'b1;
   endtask

   // ***************************************
   // Forced entry: reset low, shift, release
   // ***************************************
   task automatic force_entry(input logic [23:0] code);
      rst_n <= 1'b0;
      start_pin <= 1'b1;
      @(posedge clock);
      for (int i = 0; i < 24; i++) begin
         entry_data_pin <= code[i];
         @(posedge clock);
         entry_clock_pin <= 1'b1;
         @(posedge clock);
         entry_clock_pin <= 1'b0;
         @(posedge clock);
      end
      // Released data line shows the inverse of its last bit
      entry_data_pin <= ~code[23];
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
   endtask

   task automatic start_low();
      start_pin <= 1'b0;
   endtask
endmodule

//--- verif/isp_flash_access_control_tb.sv
`timescale 1ns/10ps
module isp_flash_access_control_tb;
   import ifa_pkg::*;
   logic clock, rst_n, reg_wr, reg_rd, flash_rvalid, jump_to_boot;
   logic emu_break, entry_data_pin, entry_clock_pin, start_pin;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, flash_wdata, flash_rdata, rv;
   logic [15:0] flash_addr;
   logic flash_rd, flash_prog, flash_erase_page, flash_erase_mass;
   logic flash_fetch_block, jump_take_boot, jump_take_flash, key_flag;
   logic boot_from_rom, isp_enable;
   logic emu_mode, opt_boot_select, opt_security;
   int failures, cmp_count, n, hi, lo, wd, code, len;
   int cnt[5];
   int codes[$] = '{0, 1, 2, 4, 7, 10};

   ifa_flash_access #(.PULSE_UNIT_CYC(1), .DEBOUNCE_CYC(4)) dut (
      .clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .flash_addr, .flash_wdata, .flash_rd, .flash_rdata, .flash_rvalid,
      .flash_prog, .flash_erase_page, .flash_erase_mass, .flash_fetch_block,
      .jump_to_boot, .jump_take_boot, .jump_take_flash, .emu_mode,
      .emu_break, .key_flag, .opt_boot_select, .opt_security,
      .boot_from_rom, .isp_enable, .entry_data_pin, .entry_clock_pin,
      .start_pin);

   ifa_host_model host (.clock, .rst_n, .entry_data_pin, .entry_clock_pin,
      .start_pin);

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Flash array answers every read one cycle later
   always @(posedge clock) begin
      flash_rvalid <= flash_rd && !flash_rvalid;
      flash_rdata <= flash_rd ? (flash_addr[7:0] ^ 8'hC3) : ~flash_rdata;
   end

   always @(negedge clock) begin
      cnt[0] += int'(flash_prog === 1'b1);
      cnt[1] += int'(flash_erase_page === 1'b1);
      cnt[2] += int'(flash_erase_mass === 1'b1);
      cnt[3] += int'(flash_fetch_block === 1'b1);
      cnt[4] += int'(key_flag === 1'b1);
   end

   // ***************************************
   // Shared tasks
   // ***************************************
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      rv = reg_rdata;
   endtask

   task automatic idle_wait();
      int k;
      for (k = 0; k < 400 && flash_fetch_block !== 1'b0; k++)
         @(posedge clock);
      if (k == 400) begin
         failures++;
         test_done();
      end
   endtask

   initial begin
      {reg_wr, reg_rd, jump_to_boot, emu_break, flash_rvalid} = '0;
      {reg_addr, reg_wdata, flash_rdata} = '0;
      {emu_mode, opt_boot_select} = 2'b11;
      failures = 0;
      cmp_count = 0;
      void'($urandom(32'h1b0302a9));
      opt_security <= 1'($urandom);
      host.hold_reset(16);
      @(posedge clock);
      rd(ADR_ADDR_HI);
      chk("addr_hi", 16'(rv), 16'h0000);
      rd(ADR_ADDR_LO);
      chk("addr_lo", 16'(rv), 16'h0000);
      rd(ADR_PTIM);
      chk("ptim_rst", 16'(rv), 16'h005A);
      rd(8'hB0);
      chk("unmapped", 16'(rv), 16'h0000);
      hi = $urandom % 128;
      lo = $urandom % 256;
      wr(ADR_ADDR_HI, 8'(hi));
      wr(ADR_ADDR_LO, 8'(lo));
      chk("flash_addr", flash_addr, 16'(hi * 256 + lo));
      wr(ADR_CMD, {5'h00, CMD_READ});
      idle_wait();
      rd(ADR_RDATA);
      chk("read_data", 16'(rv), 16'(lo ^ 8'hC3));
      wr(ADR_ADDR_HI, 8'hFF);
      wr(ADR_ADDR_LO, 8'hFF);
      chk("opt_alias", flash_addr, 16'h0FFF);
      // ***************************************
      // Write, page erase and mass erase pulses
      // ***************************************
      for (int c = 2; c <= 4; c++) begin
         code = codes[$urandom % codes.size()];
         wd = $urandom % 256;
         len = code + 1;
         wr(ADR_PTIM, 8'(code));
         rd(ADR_PTIM);
         chk("ptim", 16'(rv), 16'(code));
         wr(ADR_WDATA, 8'(wd));
         if (c == 4) begin
            wr(ADR_ADDR_HI, 8'h00);
            wr(ADR_ADDR_LO, 8'h00);
         end
         cnt = '{default: 0};
         wr(ADR_CMD, 8'(c));
         idle_wait();
         chk("prog", 16'(cnt[0]), 16'(c == 2 ? len : 0));
         chk("page", 16'(cnt[1]), 16'(c == 3 ? len : 0));
         chk("mass", 16'(cnt[2]), 16'(c == 4 ? len : 0));
         chk("fetch_block", 16'(cnt[3]), 16'(len));
         chk("flash_wdata", 16'(flash_wdata), 16'(wd));
      end
      wr(ADR_PTIM, 8'h03);
      cnt = '{default: 0};
      wr(ADR_CMD, {5'h00, CMD_WRITE});
      repeat (10) @(posedge clock);
      chk("refused_pulse", 16'(cnt[0] + cnt[3]), 16'h0000);
      rd(ADR_STATUS);
      chk("refused_flag", 16'(rv[ST_REFUSED]), 16'h0001);
      wr(ADR_STATUS, 8'(1 << ST_REFUSED));
      rd(ADR_STATUS);
      chk("refused_clr", 16'(rv[ST_REFUSED]), 16'h0000);
      // ***************************************
      // Key flag and jump decision
      // ***************************************
      for (int k = 0; k < 4; k++) begin
         code = {6'b100110, 2'($urandom)};
         if (k == 2)
            code = code ^ (8'h04 << ($urandom % 6));
         cnt = '{default: 0};
         // Breakpoint only freezes the key counter in emulation mode
         emu_mode <= (k != 3);
         // No interrupt is taken between key write and jump
         wr(ADR_KEY, 8'(code));
         for (int i = 0; i < 150; i++) begin
            emu_break <= ((k == 1 || k == 3) && i >= 10 && i < 30);
            jump_to_boot <= (i == 3);
            @(negedge clock);
            if (i == 3) begin
               chk("take_boot", 16'(jump_take_boot), 16'(k != 2));
               chk("take_flash", 16'(jump_take_flash), 16'(k == 2));
            end
            @(posedge clock);
         end
         n = (k == 2) ? 0 : (k == 1 ? 100 : 80);
         chk("key_cycles", 16'(cnt[4]), 16'(n));
      end
      // ***************************************
      // Forced entry and later plain reset
      // ***************************************
      host.force_entry(24'h5E38AC);
      @(posedge clock);
      chk("forced_boot", 16'(boot_from_rom), 16'h0001);
      chk("isp_early", 16'(isp_enable), 16'h0000);
      host.start_low();
      for (n = 0; n < 40 && isp_enable !== 1'b1; n++)
         @(posedge clock);
      chk("isp_on", 16'(n < 40), 16'h0001);
      chk("debounce", 16'(n >= 4), 16'h0001);
      rd(ADR_STATUS);
      code = {rv[ST_SECURE], rv[ST_ISP_EN], rv[ST_FORCED]};
      chk("status_bits", 16'(code), 16'({opt_security, 2'b11}));
      host.hold_reset(16);
      @(posedge clock);
      chk("plain_boot", 16'(boot_from_rom), 16'h0000);
      host.force_entry(24'h5E38AC ^ (24'h1 << ($urandom % 24)));
      @(posedge clock);
      chk("bad_code", 16'(boot_from_rom), 16'h0000);
      // Erased boot-select starts from boot ROM on a plain reset
      opt_boot_select <= 1'b0;
      host.hold_reset(16);
      @(posedge clock);
      chk("rom_boot", 16'(boot_from_rom), 16'h0001);
      test_done();
   end
endmodule
